// ===== hw/wwd_pkg.sv
// constants and types of the windowed watchdog
package wwd_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int CFG_WIN_NS = 1280;
   localparam int CFG_WIN_CYC = (CFG_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] CFG_WIN_LOAD = 9'(CFG_WIN_CYC);
   localparam int IRQ_LEAD_NS = 640;
   localparam int IRQ_LEAD_CYC = (IRQ_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] IRQ_LEAD_LOAD = 8'(IRQ_LEAD_CYC);
   localparam logic [7:0] PRESC_LAST = 8'hFF;
   localparam logic [7:0] OFS_CS = 8'h00;
   localparam logic [7:0] OFS_CNT = 8'h04;
   localparam logic [7:0] OFS_TOVAL = 8'h08;
   localparam logic [7:0] OFS_WIN = 8'h0C;
   localparam int CS_EN = 0;
   localparam int CS_IRQ_EN = 1;
   localparam int CS_UPD = 2;
   localparam int CS_WIN_EN = 3;
   localparam int CS_SRC_LO = 4;
   localparam int CS_PRES = 6;
   localparam int CS_TST_LO = 7;
   localparam int CS_WAIT_EN = 9;
   localparam int CS_STOP_EN = 10;
   localparam int CS_DBG_EN = 11;
   localparam int CS_FLG = 12;
   localparam int CS_RUN = 13;
   localparam int CS_OPEN = 14;
   localparam logic [11:0] CS_RST = 12'h215;
   localparam logic [15:0] TOVAL_RST = 16'hFFFF;
   localparam logic [15:0] WIN_RST = 16'h0000;
   localparam logic [31:0] UNLOCK_WORD_ONE = 32'h0000_1ACE;
   localparam logic [31:0] UNLOCK_WORD_TWO = 32'h0000_2BDF;
   localparam logic [31:0] REFRESH_WORD_ONE = 32'h0000_3C11;
   localparam logic [31:0] REFRESH_WORD_TWO = 32'h0000_4D22;
   typedef enum logic [0:0] {SEQ_IDLE = 1'b0, SEQ_HALF = 1'b1} wwd_seq_e;
   typedef enum logic [1:0]
   {
      TEST_OFF = 2'b00,
      TEST_USER = 2'b01,
      TEST_LOW = 2'b10,
      TEST_HIGH = 2'b11
   } wwd_test_e;
endpackage

// ===== hw/wwd_seq_if.sv
// carrier between the top and a two-word sequence detector
interface wwd_seq_if;
   logic wr;
   logic [31:0] data;
   logic abort;
   logic done;
   modport owner (output wr, output data, output abort, input done);
   modport seq (input wr, input data, input abort, output done);
endinterface

// ===== hw/wwd_tick.sv
// clock source selection, synchronisers and prescaler for counter ticks
module wwd_tick
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] src,
   input wire logic [1:0] sel,
   input wire logic div256,
   input wire logic run,
   output logic tick
);
   logic [3:0] rise;
   logic [7:0] pre_q;
   logic sel_rise;
   logic tick_q;
   genvar i;
   generate
      for (i = 0; i < 4; i++)
      begin : g_src
         logic s1_q;
         logic s2_q;
         logic s3_q;
         always_ff @(posedge clk or negedge rst_n)
            if (!rst_n)
            begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
            end
            else
            begin
               s1_q <= src[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         assign rise[i] = s2_q & ~s3_q;
      end
   endgenerate
   assign sel_rise = rise[sel];
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         pre_q <= 8'h00;
      else if (!run)
         pre_q <= 8'h00;
      else if (sel_rise)
         pre_q <= pre_q + 8'h01;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         tick_q <= 1'b0;
      else
         tick_q <= run & sel_rise & (~div256 | (pre_q == wwd_pkg::PRESC_LAST));
   assign tick = tick_q;
   chk_prescale_wrap: assert property (
      @(posedge clk) disable iff (!rst_n)
      (tick && $past(div256)) |-> ($past(pre_q) == wwd_pkg::PRESC_LAST))
      else $error("prescaled tick without full prescaler count");
endmodule // wwd_tick

// ===== hw/wwd_seq.sv
// two-word write sequence detector
module wwd_seq
#(
   parameter logic [31:0] WORD_ONE = 32'h0000_0001,
   parameter logic [31:0] WORD_TWO = 32'h0000_0002
)
(
   input wire logic clk,
   input wire logic rst_n,
   wwd_seq_if.seq sif
);
   wwd_pkg::wwd_seq_e state_q;
   logic done_q;
   // abort or wrong word drops the half sequence
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         state_q <= wwd_pkg::SEQ_IDLE;
      else if (sif.abort)
         state_q <= wwd_pkg::SEQ_IDLE;
      else if (sif.wr)
         state_q <= (sif.data == WORD_ONE) ? wwd_pkg::SEQ_HALF
                                           : wwd_pkg::SEQ_IDLE;
   // second word only counts after the first
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         done_q <= 1'b0;
      else
         done_q <= ~sif.abort & sif.wr & (sif.data == WORD_TWO)
                   & (state_q == wwd_pkg::SEQ_HALF);
   assign sif.done = done_q;
   chk_pair_order: assert property (
      @(posedge clk) disable iff (!rst_n)
      sif.done |-> ($past(state_q) == wwd_pkg::SEQ_HALF)
                   && $past(sif.wr) && ($past(sif.data) == WORD_TWO))
      else $error("sequence completed without first word");
endmodule // wwd_seq

// ===== hw/wwd_top.sv
// windowed watchdog: register port, configuration window, counter, reset
module wwd_top
(
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [3:0] CLK_SRC_IN,
   input wire logic WAIT_IN,
   input wire logic STOP_IN,
   input wire logic DEBUG_IN,
   output logic WDG_RESET,
   output logic WDG_IRQ
);
   logic [2:0] mode_s1_q;
   logic [2:0] mode_s2_q;
   logic [11:0] cs_q;
   logic [15:0] toval_q;
   logic [15:0] win_q;
   logic [15:0] cnt_q;
   logic [8:0] cfg_cnt_q;
   logic cs_wr_q;
   logic to_wr_q;
   logic wn_wr_q;
   logic irq_flag_q;
   logic running_q;
   logic lead_act_q;
   logic [7:0] lead_cnt_q;
   logic rst_q;
   logic irq_q;
   logic [31:0] rdata_q;
   logic tick;
   logic cfg_open;
   logic cfg_closing;
   logic wr_cs;
   logic wr_cnt;
   logic wr_to;
   logic wr_wn;
   logic cs_take;
   logic to_take;
   logic wn_take;
   logic suspend;
   logic counting;
   logic hit;
   logic to_evt;
   logic lead_end;
   logic ref_done;
   logic ref_bad;
   logic ref_ok;
   logic unl_done;
   logic irq_set;
   logic irq_clr;
   wwd_pkg::wwd_test_e test_mode;
   wwd_seq_if unl_if ();
   wwd_seq_if ref_if ();

   // mode pins come from other domains, so two stages first
   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
      begin
         mode_s1_q <= 3'h0;
         mode_s2_q <= 3'h0;
      end
      else
      begin
         mode_s1_q <= {DEBUG_IN, STOP_IN, WAIT_IN};
         mode_s2_q <= mode_s1_q;
      end

   assign wr_cs = WR && (ADDR == wwd_pkg::OFS_CS);
   assign wr_cnt = WR && (ADDR == wwd_pkg::OFS_CNT);
   assign wr_to = WR && (ADDR == wwd_pkg::OFS_TOVAL);
   assign wr_wn = WR && (ADDR == wwd_pkg::OFS_WIN);
   assign cfg_open = cfg_cnt_q != 9'h000;
   assign cfg_closing = cfg_cnt_q == 9'h001;
   assign cs_take = wr_cs & cfg_open & ~cs_wr_q;
   assign to_take = wr_to & cfg_open & ~to_wr_q;
   assign wn_take = wr_wn & cfg_open & ~wn_wr_q;

   // unlock and refresh words both arrive through the counter address
   assign unl_if.wr = wr_cnt;
   assign unl_if.data = WDATA;
   // no unlock once update is cleared
   assign unl_if.abort = ~cs_q[wwd_pkg::CS_UPD] | cfg_closing;
   // refresh words feed the second detector
   assign ref_if.wr = wr_cnt;
   assign ref_if.data = WDATA;
   assign ref_if.abort = ~running_q;
   assign unl_done = unl_if.done;
   assign ref_done = ref_if.done;

   wwd_seq #(
      .WORD_ONE(wwd_pkg::UNLOCK_WORD_ONE),
      .WORD_TWO(wwd_pkg::UNLOCK_WORD_TWO)
   ) u_unlock (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .sif(unl_if.seq)
   );

   wwd_seq #(
      .WORD_ONE(wwd_pkg::REFRESH_WORD_ONE),
      .WORD_TWO(wwd_pkg::REFRESH_WORD_TWO)
   ) u_refresh (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .sif(ref_if.seq)
   );

   wwd_tick u_tick (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .src(CLK_SRC_IN),
      .sel(cs_q[wwd_pkg::CS_SRC_LO +: 2]),
      .div256(cs_q[wwd_pkg::CS_PRES]),
      .run(counting),
      .tick(tick)
   );

   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         cfg_cnt_q <= wwd_pkg::CFG_WIN_LOAD;
      else if (unl_done)
         cfg_cnt_q <= wwd_pkg::CFG_WIN_LOAD;
      else if (cfg_open)
         cfg_cnt_q <= cfg_cnt_q - 9'h001;

   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         cs_wr_q <= 1'b0;
      else if (cs_take)
         cs_wr_q <= 1'b1;
      else if (unl_done)
         cs_wr_q <= 1'b0;

   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         to_wr_q <= 1'b0;
      else if (to_take)
         to_wr_q <= 1'b1;
      else if (unl_done)
         to_wr_q <= 1'b0;

   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         wn_wr_q <= 1'b0;
      else if (wn_take)
         wn_wr_q <= 1'b1;
      else if (unl_done)
         wn_wr_q <= 1'b0;

   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         cs_q <= wwd_pkg::CS_RST;
      else if (cs_take)
         cs_q <= WDATA[11:0];

   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         toval_q <= wwd_pkg::TOVAL_RST;
      else if (to_take)
         toval_q <= WDATA[15:0];

   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         win_q <= wwd_pkg::WIN_RST;
      else if (wn_take)
         win_q <= WDATA[15:0];

   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         running_q <= 1'b0;
      else
         running_q <= cs_q[wwd_pkg::CS_EN];

   // low power and debug states may freeze the count
   assign suspend = (mode_s2_q[0] & ~cs_q[wwd_pkg::CS_WAIT_EN])
                  | (mode_s2_q[1] & ~cs_q[wwd_pkg::CS_STOP_EN])
                  | (mode_s2_q[2] & ~cs_q[wwd_pkg::CS_DBG_EN]);
   assign counting = running_q & ~suspend & ~rst_q;
   assign test_mode = wwd_pkg::wwd_test_e'(cs_q[wwd_pkg::CS_TST_LO +: 2]);

   // byte tests compare one counter byte only
   always_comb
   begin
      unique case (test_mode)
         wwd_pkg::TEST_OFF:  hit = cnt_q >= toval_q;
         wwd_pkg::TEST_USER: hit = cnt_q >= toval_q;
         wwd_pkg::TEST_LOW:  hit = cnt_q[7:0] >= toval_q[7:0];
         wwd_pkg::TEST_HIGH: hit = cnt_q[15:8] >= toval_q[15:8];
      endcase
   end

   // refresh below the window value counts as a fault
   assign ref_bad = ref_done & cs_q[wwd_pkg::CS_WIN_EN] & (cnt_q < win_q);
   assign ref_ok = ref_done & ~ref_bad;
   assign to_evt = counting & hit & ~lead_act_q;
   assign lead_end = lead_act_q & (lead_cnt_q == 8'h01);

   // refresh zeroes, disable holds the count
   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         cnt_q <= 16'h0000;
      else if (ref_ok)
         cnt_q <= 16'h0000;
      else if (counting && tick && !hit)
         cnt_q <= cnt_q + 16'h0001;

   // interrupt lead time before the reset
   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
      begin
         lead_act_q <= 1'b0;
         lead_cnt_q <= 8'h00;
      end
      else if (to_evt && cs_q[wwd_pkg::CS_IRQ_EN])
      begin
         lead_act_q <= 1'b1;
         lead_cnt_q <= wwd_pkg::IRQ_LEAD_LOAD;
      end
      else if (lead_act_q && !lead_end)
         lead_cnt_q <= lead_cnt_q - 8'h01;

   // missed refresh ends in a sticky reset
   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         rst_q <= 1'b0;
      else if ((to_evt && !cs_q[wwd_pkg::CS_IRQ_EN]) || lead_end || ref_bad)
         rst_q <= 1'b1;

   assign irq_set = to_evt & cs_q[wwd_pkg::CS_IRQ_EN];
   assign irq_clr = wr_cs & WDATA[wwd_pkg::CS_FLG];

   // set wins over a clear in the same cycle
   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         irq_flag_q <= 1'b0;
      else if (irq_set)
         irq_flag_q <= 1'b1;
      else if (irq_clr)
         irq_flag_q <= 1'b0;

   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         irq_q <= 1'b0;
      else
         irq_q <= (irq_flag_q | irq_set) & cs_q[wwd_pkg::CS_IRQ_EN];

   always_ff @(posedge SYS_CLK or negedge NRST)
      if (!NRST)
         rdata_q <= 32'h0000_0000;
      else if (RD)
      begin
         unique case (ADDR)
            wwd_pkg::OFS_CS:
               rdata_q <= {17'h00000, cfg_open, running_q, irq_flag_q, cs_q};
            wwd_pkg::OFS_CNT:   rdata_q <= {16'h0000, cnt_q};
            wwd_pkg::OFS_TOVAL: rdata_q <= {16'h0000, toval_q};
            wwd_pkg::OFS_WIN:   rdata_q <= {16'h0000, win_q};
            default:            rdata_q <= 32'h0000_0000;
         endcase
      end
      else
         rdata_q <= 32'h0000_0000;

   assign RDATA = rdata_q;
   assign WDG_RESET = rst_q;
   assign WDG_IRQ = irq_q;

   chk_toval_once: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      (wr_to && to_wr_q && !unl_done) |=> (toval_q == $past(toval_q)))
      else $error("timeout register rewritten in one window");

   chk_win_once: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      (wr_wn && (wn_wr_q || !cfg_open)) |=> (win_q == $past(win_q)))
      else $error("window register written when not allowed");

   chk_cs_once: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      (wr_cs && cs_wr_q) |=> (cs_q == $past(cs_q)))
      else $error("control register rewritten in one window");

   chk_refresh_clear: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      (ref_done && !cs_q[wwd_pkg::CS_WIN_EN]) |=> (cnt_q == 16'h0000))
      else $error("refresh did not clear the counter");

   chk_timeout_reset: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      (to_evt && !cs_q[wwd_pkg::CS_IRQ_EN]) |=> WDG_RESET)
      else $error("timeout without reset");

   chk_irq_lead: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      (irq_set && !rst_q) |=> WDG_IRQ && !WDG_RESET ##1 !WDG_RESET)
      else $error("reset did not wait behind interrupt");

   chk_cnt_read: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      (RD && ADDR == wwd_pkg::OFS_CNT) |=> (RDATA[15:0] == $past(cnt_q)))
      else $error("counter read returned wrong value");

   chk_window_early: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      ref_bad |=> WDG_RESET ##1 WDG_RESET)
      else $error("early refresh did not force reset");

   chk_irq_sticky: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      (irq_set && irq_clr) |=> irq_flag_q)
      else $error("interrupt flag lost to simultaneous clear");

   chk_reset_sticky: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      WDG_RESET |=> WDG_RESET)
      else $error("watchdog reset dropped before system reset");

   chk_unlock_reopen: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      unl_done |=> (cfg_cnt_q == wwd_pkg::CFG_WIN_LOAD))
      else $error("unlock did not reopen the window");

   chk_closed_toval: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      (wr_to && !cfg_open) |=> $stable(toval_q))
      else $error("timeout register written with window closed");

   chk_count_hold: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      !counting |=> (cnt_q == $past(cnt_q)) || (cnt_q == 16'h0000))
      else $error("counter moved while not counting");
endmodule // wwd_top

// ===== test/tb_top.sv
// self-checking bench for the windowed watchdog top
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] clk_src = 4'h0;
   logic [3:0] src_run = 4'hF;
   logic [2:0] mode_pins = 3'h0;
   logic [2:0] div_q = 3'h0;
   logic [31:0] rdata;
   logic wdg_reset;
   logic wdg_irq;
   logic [31:0] a, b, c;
   logic hit;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;
   logic [15:0] tv [4] = '{16'h0004, 16'h0104, 16'h0104, 16'h0104};
   logic fast [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   wwd_top uut (.SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .CLK_SRC_IN(clk_src),
      .WAIT_IN(mode_pins[0]), .STOP_IN(mode_pins[1]),
      .DEBUG_IN(mode_pins[2]), .WDG_RESET(wdg_reset), .WDG_IRQ(wdg_irq));

   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   // sources toggle every 4 cycles, slow enough for the synchronisers
   always @(posedge sys_clk)
   begin
      div_q <= div_q + 3'h1;
      clk_src <= div_q[2] ? src_run : 4'h0;
   end

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         err_total++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      nrst <= 1'b0;
      mode_pins <= 3'h0;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
   endtask

   task automatic wr_reg(input logic [7:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= ad;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] ad, output logic [31:0] d);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= ad;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic seq2(input logic [31:0] w1, input logic [31:0] w2);
      wr_reg(wwd_pkg::OFS_CNT, w1);
      wr_reg(wwd_pkg::OFS_CNT, w2);
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic wait_hi(input int lim, input bit irq, output logic h);
      h = 1'b0;
      for (int i = 0; i < lim && h !== 1'b1; i++)
      begin
         @(posedge sys_clk);
         #1 h = irq ? wdg_irq : wdg_reset;
      end
   endtask

   initial
   begin
      do_reset();
      rd_reg(wwd_pkg::OFS_CS, a);
      check("cs reset", a, {17'h0, 3'h6, wwd_pkg::CS_RST});
      rd_reg(wwd_pkg::OFS_TOVAL, a);
      check("toval reset", a, {16'h0, wwd_pkg::TOVAL_RST});
      rd_reg(wwd_pkg::OFS_WIN, a);
      check("win reset", a, {16'h0, wwd_pkg::WIN_RST});
      rd_reg(8'h10, a);
      check("unmapped", a, 32'h0000_0000);
      // second writes in one window are dropped
      wr_reg(wwd_pkg::OFS_TOVAL, 32'h0000_1234);
      wr_reg(wwd_pkg::OFS_TOVAL, 32'h0000_4321);
      wr_reg(wwd_pkg::OFS_WIN, 32'h0000_0011);
      wr_reg(wwd_pkg::OFS_WIN, 32'h0000_0022);
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_0207);
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_0204);
      rd_reg(wwd_pkg::OFS_TOVAL, a);
      check("toval once", a, 32'h0000_1234);
      rd_reg(wwd_pkg::OFS_WIN, a);
      check("win once", a, 32'h0000_0011);
      rd_reg(wwd_pkg::OFS_CS, a);
      check("cs once", a, 32'h0000_6207);
      // disable: running clears, counter holds, refresh ignored
      do_reset();
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_0214);
      rd_reg(wwd_pkg::OFS_CS, a);
      check("cs disabled", a, 32'h0000_4214);
      rd_reg(wwd_pkg::OFS_CNT, a);
      repeat (40) @(posedge sys_clk);
      seq2(wwd_pkg::REFRESH_WORD_ONE, wwd_pkg::REFRESH_WORD_TWO);
      rd_reg(wwd_pkg::OFS_CNT, b);
      check("cnt held", b, a);
      // refresh order and broken sequences
      do_reset();
      src_run <= 4'h2;
      repeat (80) @(posedge sys_clk);
      src_run <= 4'h0;
      repeat (8) @(posedge sys_clk);
      rd_reg(wwd_pkg::OFS_CNT, a);
      check("cnt moving", 32'(a != 0), 32'h1);
      seq2(wwd_pkg::REFRESH_WORD_TWO, wwd_pkg::REFRESH_WORD_ONE);
      seq2(32'h0000_1234, wwd_pkg::REFRESH_WORD_TWO);
      rd_reg(wwd_pkg::OFS_CNT, b);
      check("bad refresh", b, a);
      seq2(wwd_pkg::REFRESH_WORD_ONE, wwd_pkg::REFRESH_WORD_TWO);
      rd_reg(wwd_pkg::OFS_CNT, c);
      check("refresh zero", c, 32'h0000_0000);
      // each source alone drives the counter
      for (int s = 0; s < 4; s++)
      begin
         do_reset();
         src_run <= ~4'(1 << s);
         wr_reg(wwd_pkg::OFS_CS, 32'h0000_0005 | (32'(s) << 4));
         repeat (64) @(posedge sys_clk);
         rd_reg(wwd_pkg::OFS_CNT, a);
         repeat (64) @(posedge sys_clk);
         rd_reg(wwd_pkg::OFS_CNT, b);
         check("src idle", b, a);
         src_run <= 4'(1 << s);
         repeat (64) @(posedge sys_clk);
         rd_reg(wwd_pkg::OFS_CNT, c);
         check("src runs", 32'(c > b), 32'h1);
      end
      // prescaler: 20 source edges give at most one tick
      do_reset();
      src_run <= 4'hF;
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_0045);
      repeat (160) @(posedge sys_clk);
      rd_reg(wwd_pkg::OFS_CNT, a);
      check("prescale", 32'(a <= 1), 32'h1);
      // 256 more source edges give exactly one more tick
      repeat (2046) @(posedge sys_clk);
      rd_reg(wwd_pkg::OFS_CNT, b);
      check("prescale tick", b, a + 32'h1);
      // wait, stop and debug suspend counting when their enable is 0
      for (int m = 0; m < 3; m++)
      begin
         do_reset();
         wr_reg(wwd_pkg::OFS_CS, 32'h0000_0005);
         mode_pins <= 3'(1 << m);
         repeat (16) @(posedge sys_clk);
         rd_reg(wwd_pkg::OFS_CNT, a);
         repeat (64) @(posedge sys_clk);
         rd_reg(wwd_pkg::OFS_CNT, b);
         check("mode hold", b, a);
         mode_pins <= 3'h0;
         repeat (64) @(posedge sys_clk);
         rd_reg(wwd_pkg::OFS_CNT, c);
         check("mode run", 32'(c > b), 32'h1);
      end
      // timeout per test mode: low byte compare fires early
      for (int t = 0; t < 4; t++)
      begin
         do_reset();
         wr_reg(wwd_pkg::OFS_TOVAL, {16'h0, tv[t]});
         wr_reg(wwd_pkg::OFS_CS, 32'h0000_0005 | (32'(t) << 7));
         wait_hi(120, 1'b0, hit);
         check("timeout", 32'(hit), 32'(fast[t]));
      end
      // early interrupt, flag clear, reset after the lead time
      do_reset();
      wr_reg(wwd_pkg::OFS_TOVAL, 32'h0000_0004);
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_0207);
      wait_hi(120, 1'b1, hit);
      check("irq", 32'(hit), 32'h1);
      check("irq first", 32'(wdg_reset), 32'h0);
      rd_reg(wwd_pkg::OFS_CS, a);
      check("flag set", 32'(a[12]), 32'h1);
      src_run <= 4'h0;
      repeat (8) @(posedge sys_clk);
      seq2(wwd_pkg::REFRESH_WORD_ONE, wwd_pkg::REFRESH_WORD_TWO);
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_1000);
      rd_reg(wwd_pkg::OFS_CS, a);
      check("flag clr", 32'(a[12]), 32'h0);
      check("irq clr", 32'(wdg_irq), 32'h0);
      repeat (60) @(posedge sys_clk);
      check("lead", 32'(wdg_reset), 32'h0);
      wait_hi(90, 1'b0, hit);
      check("late rst", 32'(hit), 32'h1);
      // enable with zero timeout raises irq beside a flag clear
      do_reset();
      src_run <= 4'h0;
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_0206);
      // no other counter address write may fall between the unlock words
      seq2(wwd_pkg::UNLOCK_WORD_ONE, wwd_pkg::UNLOCK_WORD_TWO);
      wr_reg(wwd_pkg::OFS_TOVAL, 32'h0000_0000);
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_1207);
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_1000);
      rd_reg(wwd_pkg::OFS_CS, a);
      check("set wins", a, 32'h0000_7207);
      check("irq on", 32'(wdg_irq), 32'h1);
      // window mode: late refresh fine, early refresh resets
      do_reset();
      src_run <= 4'hF;
      wr_reg(wwd_pkg::OFS_WIN, 32'h0000_0002);
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_020D);
      repeat (64) @(posedge sys_clk);
      seq2(wwd_pkg::REFRESH_WORD_ONE, wwd_pkg::REFRESH_WORD_TWO);
      check("win late", 32'(wdg_reset), 32'h0);
      seq2(wwd_pkg::REFRESH_WORD_ONE, wwd_pkg::REFRESH_WORD_TWO);
      check("win early", 32'(wdg_reset), 32'h1);
      // update bit clear: unlock refused after the window
      do_reset();
      wr_reg(wwd_pkg::OFS_CS, 32'h0000_0201);
      repeat (260) @(posedge sys_clk);
      rd_reg(wwd_pkg::OFS_CS, a);
      check("win shut", 32'(a[14]), 32'h0);
      seq2(wwd_pkg::UNLOCK_WORD_ONE, wwd_pkg::UNLOCK_WORD_TWO);
      wr_reg(wwd_pkg::OFS_TOVAL, 32'h0000_0077);
      rd_reg(wwd_pkg::OFS_TOVAL, a);
      check("locked", a, 32'h0000_FFFF);
      // unlock needs both words in order, unbroken
      do_reset();
      repeat (260) @(posedge sys_clk);
      seq2(wwd_pkg::UNLOCK_WORD_TWO, wwd_pkg::UNLOCK_WORD_ONE);
      seq2(32'h0000_1234, wwd_pkg::UNLOCK_WORD_TWO);
      rd_reg(wwd_pkg::OFS_CS, a);
      check("no unlock", 32'(a[14]), 32'h0);
      seq2(wwd_pkg::UNLOCK_WORD_ONE, wwd_pkg::UNLOCK_WORD_TWO);
      rd_reg(wwd_pkg::OFS_CS, a);
      check("unlocked", 32'(a[14]), 32'h1);
      wr_reg(wwd_pkg::OFS_TOVAL, 32'h0000_0055);
      rd_reg(wwd_pkg::OFS_TOVAL, a);
      check("rewrite", a, 32'h0000_0055);
      finish_test();
   end
endmodule // tb_top
